//--- rtl/rct_pkg.sv
// package: constants and types of the rc oscillator trim controller
package rct_pkg;

   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [3:0]  OFS_CTL0   = 4'h0;
   localparam logic [3:0]  OFS_CTL1   = 4'h4;
   localparam logic [3:0]  OFS_STAT   = 4'h8;
   localparam logic [3:0]  OFS_CLEAR  = 4'hC;

   // -----------------------------------------------------------------
   // reset values, trim maximum and word byte enable
   // -----------------------------------------------------------------
   localparam logic [31:0] CTL0_RESET = 32'h0000_2000;
   localparam logic [31:0] CTL1_RESET = 32'h2022_BB7F;
   localparam logic [5:0]  TRIM_RESET = 6'h20;
   localparam logic [5:0]  TRIM_MAX   = 6'h3F;
   localparam logic [3:0]  BE_WORD    = 4'hF;

   // -----------------------------------------------------------------
   // field positions, primary control
   // -----------------------------------------------------------------
   localparam int OK_IE_BIT   = 0;
   localparam int WARN_IE_BIT = 1;
   localparam int ERR_IE_BIT  = 2;
   localparam int EREF_IE_BIT = 3;
   localparam int TRIM_COUNTER_ENABLE_BIT   = 5;
   localparam int AUTO_BIT    = 6;
   localparam int SWPUL_BIT   = 7;
   localparam int TRIM_LSB    = 8;

   // -----------------------------------------------------------------
   // field positions, secondary control and clear register
   // -----------------------------------------------------------------
   localparam int POL_BIT     = 31;
   localparam int SEL_LSB     = 28;
   localparam int PSC_LSB     = 24;
   localparam int LIM_LSB     = 16;
   localparam int CLR_OK_BIT   = 0;
   localparam int CLR_WARN_BIT = 1;
   localparam int CLR_ERR_BIT  = 2;
   localparam int CLR_EREF_BIT = 3;

   // -----------------------------------------------------------------
   // encodings and evaluation figures
   // -----------------------------------------------------------------
   localparam logic [1:0]  SEL_SYNC_PIN = 2'h0;
   localparam logic [1:0]  SEL_CRYSTAL  = 2'h1;
   localparam logic [2:0]  STEP_NONE    = 3'h0;
   localparam logic [2:0]  STEP_FINE    = 3'h1;
   localparam logic [2:0]  STEP_COARSE  = 3'h2;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } rct_avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } rct_avm_rsp_t;

   typedef struct packed {
      logic        pol;
      logic [1:0]  sel;
      logic [2:0]  psc;
      logic [7:0]  lim;
      logic [15:0] reload;
   } rct_ctl1_t;

endpackage

//--- rtl/rct_refgen.sv
// reference sync pulse generator: source select, polarity, prescaler
`timescale 1ns/100ps
module rct_refgen (
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              enable_i,
   input  wire rct_pkg::rct_ctl1_t cfg_i,
   input  wire logic              sync_input_pin_i,
   input  wire logic              low_speed_crystal_i,
   output logic                   pulse_o
);
   import rct_pkg::*;

   typedef struct packed {
      logic       pin_s1;
      logic       pin_s2;
      logic       xtal_s1;
      logic       xtal_s2;
      logic       prev;
      logic [6:0] div;
      logic       pulse;
   } rct_refgen_st_t;

   rct_refgen_st_t st;
   rct_refgen_st_t next_st;
   logic           level;
   logic           sel_edge;
   logic [6:0]     mask;

   // -----------------------------------------------------------------
   // source select and edge detect
   // -----------------------------------------------------------------
   // pin or crystal
   // 00 pin, 01 crystal, others quiet
   always_comb begin
      unique case (cfg_i.sel)
         SEL_SYNC_PIN: level = st.pin_s2;
         SEL_CRYSTAL:  level = st.xtal_s2;
         default:      level = 1'b0;   // reserved codes give no edges
      endcase
   end

   assign sel_edge = cfg_i.pol ? (st.prev & ~level) : (~st.prev & level);
   assign mask = 7'((8'h01 << cfg_i.psc) - 8'h01);

   // next state
   always_comb begin
      next_st         = st;
      next_st.pin_s1  = sync_input_pin_i;
      next_st.pin_s2  = st.pin_s1;
      next_st.xtal_s1 = low_speed_crystal_i;
      next_st.xtal_s2 = st.xtal_s1;
      next_st.prev    = level;
      next_st.pulse   = 1'b0;
      if (!enable_i) begin
         next_st.div = 7'h00;
      end else if (sel_edge) begin
         if ((st.div & mask) == mask) begin
            next_st.pulse = 1'b1;
            next_st.div   = 7'h00;
         end else begin
            next_st.div = st.div + 7'h01;
         end
      end
   end

   // state register
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pulse_o = st.pulse;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   chk_undivided_edge: assert property (enable_i && cfg_i.psc == 3'h0 && sel_edge |=> pulse_o)
      else $error("undivided edge gave no pulse");
   chk_pulse_cause: assert property (pulse_o |-> $past(sel_edge) && $past(enable_i))
      else $error("pulse without a selected edge");
   chk_reserved_quiet: assert property (cfg_i.sel[1] [*3] |-> !pulse_o)
      else $error("pulse from a reserved source");
endmodule

//--- rtl/rct_trim_controller.sv
// rc oscillator trim controller: registers, trim counter, evaluation
`timescale 1ns/100ps
module rct_trim_controller (
   input  wire logic                 clock_i,
   input  wire logic                 rst_i,
   input  wire rct_pkg::rct_avm_req_t avm_req_i,
   output rct_pkg::rct_avm_rsp_t     avm_rsp_o,
   input  wire logic                 sync_input_pin_i,
   input  wire logic                 low_speed_crystal_i,
   output logic [5:0]                oscillator_trim_code_o,
   output logic                      irq_o
);
   import rct_pkg::*;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        ok_ie;
      logic        warn_ie;
      logic        err_ie;
      logic        eref_ie;
      logic        trim_counter_enable;
      logic        hardware_trim_enable;
      logic        sw_pulse;
      logic [5:0]  trim;
      rct_ctl1_t   ctl1;
      logic        started;
      logic        dir;
      logic        halted;
      logic [15:0] cnt;
      logic [15:0] cap;
      logic        cap_dir;
      logic        ok_f;
      logic        warn_f;
      logic        clock_error_flag_f;
      logic        miss_f;
      logic        trim_saturation_error_f;
      logic        eref_f;
      logic        irq;
   } rct_core_st_t;

   rct_core_st_t st;
   rct_core_st_t next_st;
   logic         ext_pulse;
   logic         ref_pulse;
   logic         eval;
   logic         wr;
   logic [15:0]  lim1;
   logic [15:0]  lim3;
   logic [15:0]  lim128;
   logic [31:0]  ctl0_rd;
   logic [31:0]  ctl1_rd;
   logic [31:0]  stat_rd;
   logic         err_any;

   // -----------------------------------------------------------------
   // reference pulse generation
   // -----------------------------------------------------------------
   rct_refgen u_refgen (
      .clock_i             (clock_i),
      .rst_i               (rst_i),
      .enable_i            (st.trim_counter_enable),
      .cfg_i               (st.ctl1),
      .sync_input_pin_i    (sync_input_pin_i),
      .low_speed_crystal_i (low_speed_crystal_i),
      .pulse_o             (ext_pulse)
   );

   assign ref_pulse = ext_pulse | st.sw_pulse;
   assign eval      = ref_pulse & st.trim_counter_enable & st.started;

   // evaluation thresholds
   assign lim1   = {8'h00, st.ctl1.lim};
   assign lim3   = 16'({st.ctl1.lim, 1'b0}) + lim1;
   assign lim128 = {1'b0, st.ctl1.lim, 7'h00};

   // -----------------------------------------------------------------
   // register readback
   // -----------------------------------------------------------------
   assign err_any = st.clock_error_flag_f | st.miss_f | st.trim_saturation_error_f;
   assign ctl0_rd = {18'h0_0000, st.trim, 1'b0, st.hardware_trim_enable, st.trim_counter_enable, 1'b0,
                     st.eref_ie, st.err_ie, st.warn_ie, st.ok_ie};
   assign ctl1_rd = {st.ctl1.pol, 1'b0, st.ctl1.sel, 1'b0, st.ctl1.psc,
                     st.ctl1.lim, st.ctl1.reload};
   assign stat_rd = {st.cap, st.cap_dir, 4'h0, st.trim_saturation_error_f, st.miss_f, st.clock_error_flag_f,
                     4'h0, st.eref_f, err_any, st.warn_f, st.ok_f};

   assign wr = avm_req_i.write & st.ack & (avm_req_i.byteenable == BE_WORD);

   // next state
   always_comb begin
      logic [5:0]  clr;
      logic [2:0]  step;
      logic        set_ok;
      logic        set_warn;
      logic        set_clock_error_flag;
      logic        set_miss;
      logic        set_trim_saturation_error;
      logic        set_eref;
      logic [7:0]  wide_trim;
      clr         = 6'h00;
      step        = STEP_NONE;
      set_ok      = 1'b0;
      set_warn    = 1'b0;
      set_clock_error_flag   = 1'b0;
      set_miss    = 1'b0;
      set_trim_saturation_error = 1'b0;
      set_eref    = 1'b0;
      wide_trim   = 8'h00;
      next_st     = st;
      next_st.sw_pulse = 1'b0;

      // bus: one wait cycle, read data loaded in the first
      next_st.ack = (avm_req_i.read | avm_req_i.write) & ~st.ack;
      if (avm_req_i.read && !st.ack) begin
         unique case (avm_req_i.address)
            OFS_CTL0: next_st.rdata = ctl0_rd;
            OFS_CTL1: next_st.rdata = ctl1_rd;
            OFS_STAT: next_st.rdata = stat_rd;
            default:  next_st.rdata = 32'h0000_0000;
         endcase
      end

      // register writes
      if (wr) begin
         unique case (avm_req_i.address)
            OFS_CTL0: begin
               next_st.ok_ie    = avm_req_i.writedata[OK_IE_BIT];
               next_st.warn_ie  = avm_req_i.writedata[WARN_IE_BIT];
               next_st.err_ie   = avm_req_i.writedata[ERR_IE_BIT];
               next_st.eref_ie  = avm_req_i.writedata[EREF_IE_BIT];
               next_st.trim_counter_enable    = avm_req_i.writedata[TRIM_COUNTER_ENABLE_BIT];
               next_st.hardware_trim_enable = avm_req_i.writedata[AUTO_BIT];
               next_st.sw_pulse = avm_req_i.writedata[SWPUL_BIT];
               if (!st.hardware_trim_enable) begin
                  next_st.trim = avm_req_i.writedata[TRIM_LSB +: 6];
               end
            end
            OFS_CTL1: begin
               if (!st.trim_counter_enable) begin
                  next_st.ctl1.pol    = avm_req_i.writedata[POL_BIT];
                  next_st.ctl1.sel    = avm_req_i.writedata[SEL_LSB +: 2];
                  next_st.ctl1.psc    = avm_req_i.writedata[PSC_LSB +: 3];
                  next_st.ctl1.lim    = avm_req_i.writedata[LIM_LSB +: 8];
                  next_st.ctl1.reload = avm_req_i.writedata[15:0];
               end
            end
            OFS_CLEAR: clr = avm_req_i.writedata[5:0];
            default: ;
         endcase
      end

      if (!st.trim_counter_enable) begin
         next_st.started = 1'b0;
         next_st.halted  = 1'b0;
      end else if (ref_pulse) begin
         next_st.cnt     = st.ctl1.reload;
         next_st.dir     = 1'b0;
         next_st.halted  = 1'b0;
         next_st.started = 1'b1;
         if (st.started) begin
            next_st.cap     = st.cnt;
            next_st.cap_dir = st.dir;
            if (st.cnt < lim1) begin
               set_ok = 1'b1;
            end else if (st.cnt < lim3) begin
               set_ok = 1'b1;
               step   = STEP_FINE;
            end else if (st.cnt < lim128) begin
               set_warn = 1'b1;
               step     = STEP_COARSE;
            end else if (!st.dir) begin
               set_clock_error_flag = 1'b1;
            end
         end
      end else if (st.started && !st.halted) begin
         // down, turn at zero, up, halt at top
         if (!st.dir) begin
            if (st.cnt == 16'h0000) begin
               next_st.dir = 1'b1;
               set_eref    = 1'b1;
            end else begin
               next_st.cnt = st.cnt - 16'h0001;
            end
         end else if (st.cnt >= lim128) begin
            next_st.halted = 1'b1;
            set_miss       = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 16'h0001;
         end
      end

      if (st.hardware_trim_enable && step != STEP_NONE) begin
         if (!st.dir) begin
            wide_trim = {2'h0, st.trim} + {5'h00, step};
            if (wide_trim > {2'h0, TRIM_MAX}) begin
               next_st.trim = TRIM_MAX;
               set_trim_saturation_error  = 1'b1;
            end else begin
               next_st.trim = wide_trim[5:0];
            end
         end else if ({2'h0, st.trim} < {5'h00, step}) begin
            next_st.trim = 6'h00;
            set_trim_saturation_error  = 1'b1;
         end else begin
            wide_trim    = {2'h0, st.trim} - {5'h00, step};
            next_st.trim = wide_trim[5:0];
         end
      end

      next_st.ok_f      = (st.ok_f & ~clr[CLR_OK_BIT]) | set_ok;
      next_st.warn_f    = (st.warn_f & ~clr[CLR_WARN_BIT]) | set_warn;
      next_st.clock_error_flag_f   = (st.clock_error_flag_f & ~clr[CLR_ERR_BIT]) | set_clock_error_flag;
      next_st.miss_f    = (st.miss_f & ~clr[CLR_ERR_BIT]) | set_miss;
      next_st.trim_saturation_error_f = (st.trim_saturation_error_f & ~clr[CLR_ERR_BIT]) | set_trim_saturation_error;
      next_st.eref_f    = (st.eref_f & ~clr[CLR_EREF_BIT]) | set_eref;

      next_st.irq = (next_st.ok_f & next_st.ok_ie)
                  | (next_st.warn_f & next_st.warn_ie)
                  | ((next_st.clock_error_flag_f | next_st.miss_f | next_st.trim_saturation_error_f)
                     & next_st.err_ie)
                  | (next_st.eref_f & next_st.eref_ie);
   end

   // state register
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st          <= '0;
         st.trim     <= TRIM_RESET;
         st.ctl1     <= rct_ctl1_t'({CTL1_RESET[POL_BIT], CTL1_RESET[SEL_LSB +: 2],
                                     CTL1_RESET[PSC_LSB +: 3], CTL1_RESET[LIM_LSB +: 8],
                                     CTL1_RESET[15:0]});
         st.ok_ie    <= CTL0_RESET[OK_IE_BIT];
         st.trim_counter_enable    <= CTL0_RESET[TRIM_COUNTER_ENABLE_BIT];
         st.hardware_trim_enable <= CTL0_RESET[AUTO_BIT];
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign avm_rsp_o.readdata    = st.rdata;
   assign avm_rsp_o.waitrequest = (avm_req_i.read | avm_req_i.write) & ~st.ack;
   assign oscillator_trim_code_o = st.trim;
   assign irq_o                  = st.irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_sw_write;
      wr && avm_req_i.address == OFS_CTL0 && avm_req_i.writedata[SWPUL_BIT];
   endsequence

   sequence s_up_at_top;
      st.trim_counter_enable && st.started && !st.halted && st.dir && st.cnt >= lim128 && !ref_pulse;
   endsequence

   sequence s_eval_fine_down;
      eval && st.hardware_trim_enable && !st.dir && st.cnt >= lim1 && st.cnt < lim3
      && st.trim < 6'h3F;
   endsequence

   chk_sw_single_pulse: assert property (s_sw_write |=> st.sw_pulse ##1 !st.sw_pulse)
      else $error("software pulse not a single cycle");
   chk_reload_pulse: assert property (ref_pulse && st.trim_counter_enable |=>
      st.cnt == $past(st.ctl1.reload) && !st.dir && st.started)
      else $error("counter not reloaded on pulse");
   chk_capture_value: assert property (eval |=>
      st.cap == $past(st.cnt) && st.cap_dir == $past(st.dir))
      else $error("capture does not match counter");
   chk_in_band_ok: assert property (eval && st.cnt < lim1 |=>
      st.ok_f && st.trim == $past(st.trim))
      else $error("in band pulse mishandled");
   chk_fine_step: assert property (s_eval_fine_down |=> st.trim == $past(st.trim) + 6'h01)
      else $error("fine step not applied");
   chk_warn_band: assert property (eval && st.cnt >= lim3 && st.cnt < lim128 |=> st.warn_f)
      else $error("warning flag not set");
   chk_clock_error: assert property (eval && !st.dir && st.cnt >= lim128 |=>
      st.clock_error_flag_f && st.trim == $past(st.trim))
      else $error("clock error not flagged");
   chk_ref_missed: assert property (s_up_at_top |=> st.miss_f && st.halted
      ##1 (st.halted || $past(ref_pulse) || !$past(st.trim_counter_enable)))
      else $error("missed reference not flagged");
   chk_trim_saturate: assert property ($rose(st.trim_saturation_error_f) |-> st.trim == 6'h00 || st.trim == 6'h3F)
      else $error("trim error without saturated code");
   chk_ctl1_locked: assert property (wr && avm_req_i.address == OFS_CTL1 && st.trim_counter_enable |=>
      $stable(st.ctl1))
      else $error("secondary control changed while counting");
   chk_coarse_step: assert property (eval && st.hardware_trim_enable && !st.dir && st.cnt >= lim3
      && st.cnt < lim128 && st.trim < 6'h3E |=> st.trim == $past(st.trim) + 6'h02)
      else $error("coarse step not applied");
   chk_trim_locked: assert property (wr && avm_req_i.address == OFS_CTL0 && st.hardware_trim_enable
      && !eval |=> $stable(st.trim))
      else $error("trim code written while hardware trim is on");
   chk_irq_gate: assert property (irq_o ==
      ((st.ok_f & st.ok_ie) | (st.warn_f & st.warn_ie)
       | (err_any & st.err_ie) | (st.eref_f & st.eref_ie)))
      else $error("interrupt does not follow enabled flags");
endmodule

//--- test/rct_ref_model.sv
// reference source model: sync pin pulse train and free running crystal clock
`timescale 1ns/100ps
module rct_ref_model (
   input  wire logic clock_i,
   input  wire logic sync_run_i,
   output logic      sync_input_pin_o,
   output logic      low_speed_crystal_o
);
   int   pin_cnt = 0;
   int   xtal_cnt = 0;
   logic pin_lvl = 1'b0;
   logic xtal_lvl = 1'b0;

   // defined levels from time zero, one driver each
   assign sync_input_pin_o    = pin_lvl;
   assign low_speed_crystal_o = xtal_lvl;

   // pin toggles every 10 cycles only while a run is requested
   always @(posedge clock_i) begin
      if (sync_run_i) begin
         pin_cnt <= (pin_cnt == 9) ? 0 : pin_cnt + 1;
         if (pin_cnt == 9) begin
            pin_lvl <= ~pin_lvl;
         end
      end
   end

   // crystal runs free, half period of 30 cycles
   always @(posedge clock_i) begin
      xtal_cnt <= (xtal_cnt == 29) ? 0 : xtal_cnt + 1;
      if (xtal_cnt == 29) begin
         xtal_lvl <= ~xtal_lvl;
      end
   end
endmodule

//--- test/tb_top.sv
// testbench: register access, trim evaluation and reference source scenarios
`timescale 1ns/100ps
module tb_top;
   import rct_pkg::*;
   logic         clock_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         sync_run = 1'b0;
   logic         pin;
   logic         xtal;
   logic [5:0]   trim;
   logic         irq;
   rct_avm_req_t req = '0;
   rct_avm_rsp_t rsp;
   logic [31:0]  rd;
   int           err_count = 0;
   int           check_count = 0;

   // 20 MHz clock
   always #25 clock_i = ~clock_i;

   rct_trim_controller rct_trim_controller_i (
      .clock_i               (clock_i),
      .rst_i                 (rst_i),
      .avm_req_i             (req),
      .avm_rsp_o             (rsp),
      .sync_input_pin_i      (pin),
      .low_speed_crystal_i   (xtal),
      .oscillator_trim_code_o(trim),
      .irq_o                 (irq)
   );

   rct_ref_model rct_ref_model_i (
      .clock_i            (clock_i),
      .sync_run_i         (sync_run),
      .sync_input_pin_o   (pin),
      .low_speed_crystal_o(xtal)
   );

   task end_sim;
      $display("mismatches %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon word access, held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      req <= '{read: ~wr, write: wr, address: a, byteenable: BE_WORD, writedata: d};
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 20);
      rd = rsp.readdata;
      req <= '0;
      if (rsp.waitrequest !== 1'b0) begin
         err_count++;
         end_sim;
      end
   endtask

   task wait_cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask

   task chk_cap(input int lo, input int hi);
      chk({31'h0, (32'(rd[31:16]) >= lo && 32'(rd[31:16]) <= hi)}, 32'h0000_0001);
   endtask

   // reset values, read back, trim permission, secondary lock
   task s_regs;
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b0, OFS_CTL0, 32'h0000_0000);
      chk(rd, CTL0_RESET);
      bus(1'b0, OFS_CTL1, 32'h0000_0000);
      chk(rd, CTL1_RESET);
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk({26'h0, trim}, {26'h0, TRIM_RESET});
      bus(1'b1, OFS_CTL0, 32'h0000_1580);
      bus(1'b0, OFS_CTL0, 32'h0000_0000);
      chk(rd, 32'h0000_1500);
      chk({26'h0, trim}, 32'h0000_0015);
      bus(1'b1, OFS_CTL0, 32'h0000_0140);
      bus(1'b1, OFS_CTL0, 32'h0000_3F40);
      bus(1'b0, OFS_CTL0, 32'h0000_0000);
      chk(rd, 32'h0000_0140);
      bus(1'b1, OFS_CTL0, 32'h0000_0020);
      bus(1'b1, OFS_CTL1, 32'h1234_5678);
      bus(1'b0, OFS_CTL1, 32'h0000_0000);
      chk(rd, CTL1_RESET);
      bus(1'b1, OFS_CTL0, 32'h0000_0000);
   endtask

   // two software pulses, gap idle cycles between the two bus writes, limit 8, hardware_trim_enable on
   task s_eval(input logic [15:0] r, input int gap, input logic [5:0] t0,
               input logic [15:0] fl, input logic [5:0] t1, input int lo, input int hi);
      bus(1'b1, OFS_CTL1, {16'h0008, r});
      bus(1'b1, OFS_CLEAR, 32'h0000_000F);
      bus(1'b1, OFS_CTL0, {18'h0, t0, 8'hE0});
      wait_cyc(gap);
      bus(1'b1, OFS_CTL0, {18'h0, t0, 8'hE0});
      wait_cyc(3);
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      chk(rd & 32'h0000_870F, {16'h0000, fl});
      chk({26'h0, trim}, {26'h0, t1});
      chk_cap(lo, hi);
      bus(1'b1, OFS_CTL0, 32'h0000_0000);
   endtask

   // warning flag gated by its enable, cleared by software
   task s_irq;
      chk({31'h0, irq}, 32'h0000_0000);
      bus(1'b1, OFS_CTL0, 32'h0000_0002);
      wait_cyc(2);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, OFS_CLEAR, 32'h0000_0002);
      wait_cyc(2);
      chk({31'h0, irq}, 32'h0000_0000);
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      chk(rd & 32'h0000_0002, 32'h0000_0000);
      bus(1'b1, OFS_CTL0, 32'h0000_0000);
   endtask

   // external reference through select, polarity and prescaler
   task s_ext(input logic [31:0] c1, input int w, input logic [15:0] fl,
              input int lo, input int hi);
      bus(1'b1, OFS_CTL1, c1);
      bus(1'b1, OFS_CLEAR, 32'h0000_000F);
      sync_run <= 1'b1;
      bus(1'b1, OFS_CTL0, 32'h0000_2020);
      wait_cyc(w);
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      chk(rd & 32'h0000_870F, {16'h0000, fl});
      chk_cap(lo, hi);
      chk({26'h0, trim}, 32'h0000_0020);
      bus(1'b1, OFS_CTL0, 32'h0000_0000);
      sync_run <= 1'b0;
   endtask

   // main sequence
   initial begin
      wait_cyc(3);
      rst_i <= 1'b0;
      s_regs;
      s_eval(16'h0008, 0, 6'h14, 16'h0001, 6'h14, 3, 7);
      s_eval(16'h0014, 0, 6'h14, 16'h0001, 6'h15, 15, 19);
      s_eval(16'h0064, 0, 6'h14, 16'h0002, 6'h16, 95, 99);
      s_irq;
      s_eval(16'h07D0, 0, 6'h14, 16'h0104, 6'h14, 1995, 1999);
      s_eval(16'h0064, 0, 6'h3E, 16'h0406, 6'h3F, 95, 99);
      s_eval(16'h0014, 30, 6'h20, 16'h8009, 6'h1F, 9, 16);
      s_eval(16'h0014, 80, 6'h00, 16'h840E, 6'h00, 58, 66);
      s_eval(16'h0014, 1100, 6'h05, 16'h820C, 6'h05, 1024, 1024);
      s_ext(32'h8108_0064, 300, 16'h0002, 57, 62);
      s_ext(32'h1008_0064, 300, 16'h0002, 37, 42);
      // crystal / 32 gives 1920 cycles: reload 1919, limit half a step
      s_ext(32'h1501_077F, 4000, 16'h0001, 0, 0);
      end_sim;
   end
endmodule
